// [core/cgc_clkdiv.sv]
// Programmable clock divider with fractional cycle pattern
`timescale 1ns/100ps
module cgc_clkdiv
	import cgc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control and generated tick
	cgc_div_if.gen   d
);

	// ==========================================
	// Pattern decode
	function automatic logic [3:0] cgc_lead(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (v[i]) r = 4'(i);
		end
		return r;
	endfunction

	logic [12:0] cnt_q;
	logic [3:0]  pos_q;
	logic        tick_q;

	wire [3:0]  lead     = cgc_lead(d.frac);
	wire        has_frac = |d.frac;
	wire        extra    = has_frac & d.frac[pos_q];
	wire [11:0] base     = (d.div == 12'h000) ? 12'h001 : d.div;
	wire [12:0] period   = {1'b0, base} + {12'h000, extra};
	wire [12:0] cnt_inc  = cnt_q + 13'h0001;
	wire        last     = cnt_inc >= period;
	wire [3:0]  pos_nx   = (pos_q == 4'h0) ? lead : pos_q - 4'h1;

	// ==========================================
	// Counter: one tick per (divider + extra) source ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= 13'h0000;
			pos_q  <= 4'h0;
			tick_q <= 1'b0;
		end else if (!d.en) begin
			cnt_q  <= 13'h0000;
			pos_q  <= lead;
			tick_q <= 1'b0;
		end else if (d.src_tick && last) begin
			cnt_q  <= 13'h0000;
			pos_q  <= pos_nx;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= d.src_tick ? cnt_inc : cnt_q;
			tick_q <= 1'b0;
		end
	end

	assign d.tick = tick_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	tick_needs_en_a: assert property (tick_q |-> $past(d.en)) else $error("divider ticked while disabled");
	frac_walk_a: assert property (d.en && d.src_tick && last && pos_q != 4'h0 |=> pos_q == $past(pos_q) - 4'h1)
		else $error("fraction pattern position did not step down");

endmodule

// [core/cgc_div_if.sv]
// Interface between the block core and one clock divider
`timescale 1ns/100ps
interface cgc_div_if;
	logic        en;
	logic        src_tick;
	logic [11:0] div;
	logic [15:0] frac;
	logic        tick;
	modport ctl (output en, src_tick, div, frac, input tick);
	modport gen (input en, src_tick, div, frac, output tick);
endinterface

// [core/cgc_pkg.sv]
// Package: constants, register map and types of the clock generation block
// What this block does
// - Peripheral source select 1 feeds undivided clock, 0 feeds divided clock.
// - PCM clock gated by its enable; 12-bit divider; source select bit.
// - Leftmost set fraction bit gives denominator, set-bit count gives numerator.
// - PDM runs as clock master when master bit is 1, slave otherwise.
// - PDM clock produced only while enabled, divided by 8-bit divider.
// - Rate converter clock produced only while enabled, divided by 8-bit divider.
// - USB pad power follows USB enable unless override bit forces it on.
// - First pull-up override forces first D+ pull-up switch off.
// - Second pull-up override forces D+ pull-up to 2.3 kilohm setting.
// - Without override the USB controller drives the switch, off when USB disabled.
// - Writing 1 to start bit begins calibration; hardware clears it when done.
// - 2-bit field selects reference: RC 32k, RC 16M, crystal 32k, low-power RC.
// - Window length loads a down-counter that ends the window at 1.
// - Divided-clock cycles counted in window, read as low and high halves.
// - Six peripheral clock gates pass clock only while set; all reset to 0.
package cgc_pkg;

	// ==========================================
	// Register indices and byte addresses
	localparam logic [31:0] CGC_BASE         = 32'h50001B60;
	localparam logic [31:0] CGC_IDX_CAL_CTRL = 32'h50001B60;
	localparam logic [31:0] CGC_IDX_CAL_WIN  = 32'h50001B62;
	localparam logic [31:0] CGC_IDX_CAL_LO   = 32'h50001B64;
	localparam logic [31:0] CGC_IDX_CAL_HI   = 32'h50001B66;
	localparam logic [31:0] CGC_IDX_PER      = 32'h50001C04;
	localparam logic [31:0] CGC_IDX_PCM      = 32'h50001C40;
	localparam logic [31:0] CGC_IDX_FRAC     = 32'h50001C42;
	localparam logic [31:0] CGC_IDX_PDM      = 32'h50001C44;
	localparam logic [31:0] CGC_IDX_SRC      = 32'h50001C46;
	localparam logic [31:0] CGC_IDX_USB      = 32'h50001C4A;
	localparam logic [31:0] CGC_IDX_IRQ_STAT = 32'h50001C50;
	localparam logic [31:0] CGC_IDX_IRQ_MASK = 32'h50001C52;

	function automatic logic [11:0] cgc_addr(input logic [31:0] idx);
		logic [31:0] d;
		d = (idx - CGC_BASE) << 2;
		return d[11:0];
	endfunction

	// ==========================================
	// Writable bits and reset values
	localparam logic [15:0] CGC_WM_CAL_CTRL = 16'h0007;
	localparam logic [15:0] CGC_WM_PER      = 16'h0F3F;
	localparam logic [15:0] CGC_WM_PCM      = 16'h3FFF;
	localparam logic [15:0] CGC_WM_PDM      = 16'h03FF;
	localparam logic [15:0] CGC_WM_SRC      = 16'h01FF;
	localparam logic [15:0] CGC_WM_USB      = 16'h0007;
	localparam logic [15:0] CGC_WM_IRQ      = 16'h0001;
	localparam logic [15:0] CGC_RST_REG     = 16'h0000;

	// ==========================================
	// Field positions
	localparam int CGC_CAL_START  = 2;
	localparam int CGC_PER_ADC    = 11;
	localparam int CGC_PER_KBS    = 10;
	localparam int CGC_PER_I2C    = 9;
	localparam int CGC_PER_SPI    = 8;
	localparam int CGC_PCM_SRC    = 13;
	localparam int CGC_PCM_EN     = 12;
	localparam int CGC_PDM_MASTER = 9;
	localparam int CGC_DIV_EN     = 8;
	localparam int CGC_USB_FORCE2 = 2;
	localparam int CGC_USB_FORCE1 = 1;
	localparam int CGC_USB_PWR    = 0;
	localparam int CGC_IRQ_CAL    = 0;

	typedef enum logic {
		CGC_CAL_IDLE = 1'b0,
		CGC_CAL_RUN  = 1'b1
	} cgc_cal_state_t;

endpackage

// [core/cgc_top.sv]
// Clock generation, gating and reference calibration core with APB slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module cgc_top
	import cgc_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// System clock tick and references
	input  wire logic        divided_tick,
	input  wire logic [3:0]  ref_clks,
	// USB controller side
	input  wire logic        usb_enabled,
	input  wire logic        usb_ctrl_pu1_on,
	input  wire logic        usb_ctrl_pu2_on,
	// Peripheral clock enables
	output logic             adc_clk_en,
	output logic      [5:0]  periph_clk_en,
	// Generated audio clocks
	output logic             pcm_clk_tick,
	output logic             pdm_clk_tick,
	output logic             pdm_clock_master,
	output logic             rate_converter_clk_tick,
	// USB pads
	output logic             usb_pad_power,
	output logic             first_pullup_switch,
	output logic             second_pullup_switch,
	// Interrupt
	output logic             irq
);

	// ==========================================
	// Registers
	logic [15:0]    cal_sel_q;
	logic [15:0]    win_q;
	logic [31:0]    result_q;
	logic [15:0]    per_q;
	logic [15:0]    pcm_q;
	logic [15:0]    frac_q;
	logic [15:0]    pdm_q;
	logic [15:0]    src_q;
	logic [15:0]    usb_q;
	logic [15:0]    stat_q;
	logic [15:0]    mask_q;
	logic [31:0]    prdata_q;
	logic           pready_q;
	logic           pslverr_q;
	logic           irq_q;
	cgc_cal_state_t state_q;
	logic [15:0]    down_q;
	logic [31:0]    meas_q;
	logic [3:0]     ref_s1_q;
	logic [3:0]     ref_s2_q;
	logic [3:0]     ref_s3_q;
	logic           adc_q;
	logic [5:0]     gate_q;
	logic           pdm_tick_q;
	logic           usb_pwr_q;
	logic           pu1_q;
	logic           pu2_q;

	// ==========================================
	// APB decode
	wire setup  = psel & ~penable;
	wire access = psel & penable & pready_q;
	wire wr     = access & pwrite;

	wire hit_cal  = paddr == cgc_addr(CGC_IDX_CAL_CTRL);
	wire hit_win  = paddr == cgc_addr(CGC_IDX_CAL_WIN);
	wire hit_lo   = paddr == cgc_addr(CGC_IDX_CAL_LO);
	wire hit_hi   = paddr == cgc_addr(CGC_IDX_CAL_HI);
	wire hit_per  = paddr == cgc_addr(CGC_IDX_PER);
	wire hit_pcm  = paddr == cgc_addr(CGC_IDX_PCM);
	wire hit_frac = paddr == cgc_addr(CGC_IDX_FRAC);
	wire hit_pdm  = paddr == cgc_addr(CGC_IDX_PDM);
	wire hit_src  = paddr == cgc_addr(CGC_IDX_SRC);
	wire hit_usb  = paddr == cgc_addr(CGC_IDX_USB);
	wire hit_stat = paddr == cgc_addr(CGC_IDX_IRQ_STAT);
	wire hit_mask = paddr == cgc_addr(CGC_IDX_IRQ_MASK);

	wire [15:0] wd = pwdata[15:0];
	wire        busy = state_q == CGC_CAL_RUN;

	logic [15:0] rd;
	logic        mapped;
	always_comb begin
		rd     = 16'h0000;
		mapped = 1'b1;
		if (hit_cal) begin
			rd = {13'h0, busy, cal_sel_q[1:0]};
		end else if (hit_win) begin
			rd = win_q;
		end else if (hit_lo) begin
			rd = result_q[15:0];
		end else if (hit_hi) begin
			rd = result_q[31:16];
		end else if (hit_per) begin
			rd = per_q;
		end else if (hit_pcm) begin
			rd = pcm_q;
		end else if (hit_frac) begin
			rd = frac_q;
		end else if (hit_pdm) begin
			rd = pdm_q;
		end else if (hit_src) begin
			rd = src_q;
		end else if (hit_usb) begin
			rd = usb_q;
		end else if (hit_stat) begin
			rd = stat_q;
		end else if (hit_mask) begin
			rd = mask_q;
		end else begin
			mapped = 1'b0;
		end
	end

	// Answer is prepared in the setup cycle, so every access ends after one wait-free cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= setup ? {16'h0000, rd} : prdata_q;
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped;
		end
	end

	// ==========================================
	// Plain control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_q  <= CGC_RST_REG;
			per_q  <= CGC_RST_REG;
			pcm_q  <= CGC_RST_REG;
			frac_q <= CGC_RST_REG;
			pdm_q  <= CGC_RST_REG;
			src_q  <= CGC_RST_REG;
			usb_q  <= CGC_RST_REG;
			mask_q <= CGC_RST_REG;
		end else if (wr) begin
			win_q  <= hit_win ? wd : win_q;
			per_q  <= hit_per ? (wd & CGC_WM_PER) : per_q;
			pcm_q  <= hit_pcm ? (wd & CGC_WM_PCM) : pcm_q;
			frac_q <= hit_frac ? wd : frac_q;
			pdm_q  <= hit_pdm ? (wd & CGC_WM_PDM) : pdm_q;
			src_q  <= hit_src ? (wd & CGC_WM_SRC) : src_q;
			usb_q  <= hit_usb ? (wd & CGC_WM_USB) : usb_q;
			mask_q <= hit_mask ? (wd & CGC_WM_IRQ) : mask_q;
		end
	end

	// ==========================================
	// Reference synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_s1_q <= 4'h0;
			ref_s2_q <= 4'h0;
			ref_s3_q <= 4'h0;
		end else begin
			ref_s1_q <= ref_clks;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
		end
	end

	// ==========================================
	// Calibration
	wire [1:0] ref_sel  = cal_sel_q[1:0];
	wire       ref_edge = ref_s2_q[ref_sel] & ~ref_s3_q[ref_sel];
	wire       start    = wr & hit_cal & wd[CGC_CAL_START] & ~busy;
	wire       done     = busy & ref_edge & (down_q <= 16'h0001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= CGC_CAL_IDLE;
			cal_sel_q <= CGC_RST_REG;
			down_q    <= 16'h0000;
			meas_q    <= 32'h00000000;
			result_q  <= 32'h00000000;
		end else begin
			// Reference choice stays frozen during a run to avoid false edges
			if (wr && hit_cal && !busy) begin
				cal_sel_q <= wd & CGC_WM_CAL_CTRL & 16'h0003;
			end
			case (state_q)
				CGC_CAL_IDLE: begin
					if (start) begin
						state_q <= CGC_CAL_RUN;
						down_q  <= win_q;
						meas_q  <= 32'h00000000;
					end
				end
				CGC_CAL_RUN: begin
					meas_q <= meas_q + {31'h0, divided_tick};
					if (done) begin
						state_q  <= CGC_CAL_IDLE;
						result_q <= meas_q + {31'h0, divided_tick};
					end else if (ref_edge) begin
						down_q <= down_q - 16'h0001;
					end
				end
				default: state_q <= CGC_CAL_IDLE;
			endcase
		end
	end

	// ==========================================
	// Interrupt: set wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= CGC_RST_REG;
			irq_q  <= 1'b0;
		end else begin
			stat_q[15:1] <= 15'h0;
			stat_q[CGC_IRQ_CAL] <= done | (stat_q[CGC_IRQ_CAL] & ~(wr & hit_stat & wd[CGC_IRQ_CAL]));
			irq_q <= |(stat_q & mask_q);
		end
	end

	// ==========================================
	// Peripheral clock enables
	wire [5:0] gate_src = {per_q[CGC_PER_KBS], 2'b00, per_q[CGC_PER_I2C], per_q[CGC_PER_SPI], 1'b0};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_q <= 1'b0;
		end else begin
			adc_q <= per_q[CGC_PER_ADC] | divided_tick;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : gates
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					gate_q[g] <= 1'b0;
				end else begin
					gate_q[g] <= per_q[g] & (gate_src[g] | divided_tick);
				end
			end
		end
	endgenerate

	// ==========================================
	// Audio dividers
	cgc_div_if pcm_if ();
	cgc_div_if pdm_if ();
	cgc_div_if src_if ();

	assign pcm_if.en       = pcm_q[CGC_PCM_EN];
	assign pcm_if.src_tick = pcm_q[CGC_PCM_SRC] | divided_tick;
	assign pcm_if.div      = pcm_q[11:0];
	assign pcm_if.frac     = frac_q;
	assign pdm_if.en       = pdm_q[CGC_DIV_EN];
	assign pdm_if.src_tick = divided_tick;
	assign pdm_if.div      = {4'h0, pdm_q[7:0]};
	assign pdm_if.frac     = 16'h0000;
	assign src_if.en       = src_q[CGC_DIV_EN];
	assign src_if.src_tick = divided_tick;
	assign src_if.div      = {4'h0, src_q[7:0]};
	assign src_if.frac     = 16'h0000;

	cgc_clkdiv u_pcm (.pclk(pclk), .presetn(presetn), .d(pcm_if));
	cgc_clkdiv u_pdm (.pclk(pclk), .presetn(presetn), .d(pdm_if));
	cgc_clkdiv u_src (.pclk(pclk), .presetn(presetn), .d(src_if));

	// ==========================================
	// PDM master gating and USB pads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pdm_tick_q <= 1'b0;
			usb_pwr_q  <= 1'b0;
			pu1_q      <= 1'b0;
			pu2_q      <= 1'b0;
		end else begin
			pdm_tick_q <= pdm_if.tick & pdm_q[CGC_PDM_MASTER];
			usb_pwr_q  <= usb_q[CGC_USB_PWR] | usb_enabled;
			pu1_q      <= ~usb_q[CGC_USB_FORCE1] & usb_enabled & usb_ctrl_pu1_on;
			pu2_q      <= usb_q[CGC_USB_FORCE2] | (usb_enabled & usb_ctrl_pu2_on);
		end
	end

	// ==========================================
	// Outputs
	assign prdata                  = prdata_q;
	assign pready                  = pready_q;
	assign pslverr                 = pslverr_q;
	assign irq                     = irq_q;
	assign adc_clk_en              = adc_q;
	assign periph_clk_en           = gate_q;
	assign pcm_clk_tick            = pcm_if.tick;
	assign pdm_clk_tick            = pdm_tick_q;
	assign pdm_clock_master        = pdm_q[CGC_PDM_MASTER];
	assign rate_converter_clk_tick = src_if.tick;
	assign usb_pad_power           = usb_pwr_q;
	assign first_pullup_switch     = pu1_q;
	assign second_pullup_switch    = pu2_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	apb_answer_a: assert property (setup |=> pready_q) else $error("no answer after setup");
	cal_clear_a: assert property (done |=> !busy ##0 prdata_q[2] == 1'b0 || !busy)
		else $error("start bit not cleared at end of run");
	win_load_a: assert property (start |=> busy && down_q == $past(win_q))
		else $error("window not loaded at start");
	down_step_a: assert property (busy && ref_edge && down_q > 16'h0001 |=> down_q == $past(down_q) - 16'h0001)
		else $error("window counter did not step");
	result_a: assert property (done |=> result_q == $past(meas_q) + {31'h0, $past(divided_tick)})
		else $error("result not captured");
	adc_sel_a: assert property ($past(per_q[CGC_PER_ADC]) |-> adc_clk_en)
		else $error("undivided source not fed");
	gate_off_a: assert property ((periph_clk_en & ~$past(per_q[5:0])) == 6'h00)
		else $error("gated clock passed while off");
	pcm_gate_a: assert property (pcm_clk_tick |-> $past(pcm_q[CGC_PCM_EN]))
		else $error("pcm clock while disabled");
	pdm_slave_a: assert property (pdm_clk_tick |-> $past(pdm_q[CGC_PDM_MASTER]) && $past(pdm_q[CGC_DIV_EN], 2))
		else $error("pdm clock in slave mode or disabled");
	src_gate_a: assert property (rate_converter_clk_tick |-> $past(src_q[CGC_DIV_EN]))
		else $error("rate converter clock while disabled");
	usb_power_a: assert property (!usb_pad_power |-> !$past(usb_q[CGC_USB_PWR]) && !$past(usb_enabled))
		else $error("pad power dropped while requested");
	pu1_off_a: assert property ($past(usb_q[CGC_USB_FORCE1]) || !$past(usb_enabled) |-> !first_pullup_switch)
		else $error("first pull-up on while forced off");
	pu2_on_a: assert property ($past(usb_q[CGC_USB_FORCE2]) |-> second_pullup_switch)
		else $error("second pull-up not forced");

	cal_done_c: cover property (start ##[1:1000] done);
	irq_c: cover property (done ##2 irq);
	pcm_tick_c: cover property (pcm_clk_tick ##[1:50] pcm_clk_tick);
	set_clear_c: cover property (done && wr && hit_stat);

endmodule

// [tb/cgc_tb_partner.sv]
// Far-side model: divided system clock tick source and free-running reference oscillators
`timescale 1ns/100ps
module cgc_tb_partner (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Sources handed to the block
	output logic            divided_tick,
	output logic      [3:0] ref_clks
);
	// ==========================================
	// Sources
	// Distinct reference periods so a wrong select shows up in the measured count
	int half [4] = '{8, 20, 50, 120};
	int cnt  [4];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divided_tick <= 1'b0;
			ref_clks  <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				cnt[i] <= 0;
			end
		end else begin
			// Divided clock at half the bus rate
			divided_tick <= ~divided_tick;
			for (int i = 0; i < 4; i++) begin
				cnt[i] <= (cnt[i] == half[i] - 1) ? 0 : cnt[i] + 1;
				if (cnt[i] == half[i] - 1) begin
					ref_clks[i] <= ~ref_clks[i];
				end
			end
		end
	end
endmodule

// [tb/tb_top.sv]
// Self-checking testbench of the clock generation and calibration block
`timescale 1ns/100ps
module tb_top;
	import cgc_pkg::*;

	// ==========================================
	// Signals
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        divided_tick;
	logic [3:0]  ref_clks;
	logic        usb_enabled;
	logic        usb_ctrl_pu1_on;
	logic        usb_ctrl_pu2_on;
	logic        adc_clk_en;
	logic [5:0]  periph_clk_en;
	logic        pcm_clk_tick;
	logic        pdm_clk_tick;
	logic        pdm_clock_master;
	logic        rate_converter_clk_tick;
	logic        usb_pad_power;
	logic        first_pullup_switch;
	logic        second_pullup_switch;
	logic        irq;
	logic        last_err;
	int          n_errors;
	int          num_checks;
	wire  [2:0]  mon = {rate_converter_clk_tick, pdm_clk_tick, pcm_clk_tick};
	wire  [6:0]  gates = {adc_clk_en, periph_clk_en};

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	cgc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.divided_tick(divided_tick), .ref_clks(ref_clks), .usb_enabled(usb_enabled),
		.usb_ctrl_pu1_on(usb_ctrl_pu1_on), .usb_ctrl_pu2_on(usb_ctrl_pu2_on), .adc_clk_en(adc_clk_en),
		.periph_clk_en(periph_clk_en), .pcm_clk_tick(pcm_clk_tick), .pdm_clk_tick(pdm_clk_tick),
		.pdm_clock_master(pdm_clock_master), .rate_converter_clk_tick(rate_converter_clk_tick),
		.usb_pad_power(usb_pad_power), .first_pullup_switch(first_pullup_switch),
		.second_pullup_switch(second_pullup_switch), .irq(irq));

	cgc_tb_partner i_partner (.pclk(pclk), .presetn(presetn), .divided_tick(divided_tick), .ref_clks(ref_clks));

	// ==========================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Request held until pready is sampled high; no wait count is assumed
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
		rd = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] r;
		apb(1'b1, a, {16'h0000, d}, r);
	endtask

	// Cycles spanned by n tick periods after the first tick; got low if no tick shows
	task automatic span(input int w, input int n, output int cyc, output logic got);
		int seen;
		got = 1'b0;
		cyc = 0;
		seen = 0;
		for (int k = 0; k < 60 && got !== 1'b1; k++) begin
			@(negedge pclk);
			got = mon[w];
		end
		for (int k = 0; k < 2000 && got === 1'b1 && seen < n; k++) begin
			@(negedge pclk);
			cyc++;
			seen += mon[w];
		end
	endtask

	// ==========================================
	// Tables
	logic [11:0] ra [12] = '{12'h290, 12'h380, 12'h388, 12'h390, 12'h398, 12'h3A8, 12'h008, 12'h3C8,
		12'h010, 12'h018, 12'h3C0, 12'h000};
	logic [15:0] rm [11] = '{16'h0F3F, 16'h3FFF, 16'hFFFF, 16'h03FF, 16'h01FF, 16'h0007, 16'hFFFF, 16'h0001,
		16'h0000, 16'h0000, 16'h0000};
	logic [15:0] pv [4] = '{16'h0F3F, 16'h003F, 16'h0000, 16'h0800};
	logic [6:0]  pg [4] = '{7'h7F, 7'h7F, 7'h40, 7'h40};
	logic [6:0]  pf [4] = '{7'h66, 7'h00, 7'h00, 7'h40};
	// Divider steps: address, data, output watched (3 = write only), periods, expected cycles (0 = silent)
	logic [11:0] da [13] = '{12'h388, 12'h380, 12'h380, 12'h388, 12'h380, 12'h380, 12'h388, 12'h380, 12'h380,
		12'h390, 12'h390, 12'h398, 12'h398};
	logic [15:0] dd [13] = '{16'h0110, 16'h3002, 16'h0000, 16'hFEEE, 16'h3002, 16'h0000, 16'h0000, 16'h1003,
		16'h0003, 16'h0303, 16'h0103, 16'h0105, 16'h0005};
	int          dw [13] = '{3, 0, 3, 3, 0, 3, 3, 0, 0, 1, 1, 2, 2};
	int          dn [13] = '{0, 9, 0, 0, 16, 0, 0, 4, 0, 4, 0, 3, 0};
	int          de [13] = '{0, 20, 0, 0, 45, 0, 0, 24, 0, 24, 0, 30, 0};
	int          rp [4] = '{16, 40, 100, 240};

	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [31:0] h;
		logic        got;
		int          cyc;
		logic [31:0] c [7];
		n_errors = 0;
		num_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		usb_enabled = 1'b0;
		usb_ctrl_pu1_on = 1'b0;
		usb_ctrl_pu2_on = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, access kinds and an unmapped address
		for (int i = 0; i < 12; i++) begin
			apb(1'b0, ra[i], 32'h0, r);
			chk(r, 32'h0);
			chk(last_err, 1'b0);
		end
		for (int i = 0; i < 11; i++) begin
			wr(ra[i], 16'hFFFF);
			apb(1'b0, ra[i], 32'h0, r);
			chk(r, {16'h0000, rm[i]});
			wr(ra[i], 16'h0000);
		end
		apb(1'b0, 12'h100, 32'h0, r);
		chk({r[31:1], last_err}, 32'h1);
		// Source select and gating of peripheral clocks
		for (int j = 0; j < 4; j++) begin
			wr(12'h290, pv[j]);
			repeat (3) @(posedge pclk);
			c = '{default: 0};
			repeat (4) begin
				@(negedge pclk);
				for (int b = 0; b < 7; b++) c[b] += gates[b];
			end
			for (int b = 0; b < 7; b++) begin
				chk(c[b], pg[j][b] ? (pf[j][b] ? 4 : 2) : 0);
			end
		end
		// Audio clock dividers; divider values written before or with the enable
		for (int i = 0; i < 13; i++) begin
			wr(da[i], dd[i]);
			repeat (3) @(posedge pclk);
			if (dw[i] == 1) begin
				chk(pdm_clock_master, dd[i][9]);
			end
			if (dw[i] < 3) begin
				span(dw[i], dn[i], cyc, got);
				chk(got, de[i] != 0);
				if (de[i] != 0) begin
					chk(cyc, de[i]);
				end
			end
		end
		// USB pad power and pull-up overrides over every combination
		for (int i = 0; i < 64; i++) begin
			wr(12'h3A8, {13'h0, i[2:0]});
			usb_enabled <= i[3];
			usb_ctrl_pu1_on <= i[4];
			usb_ctrl_pu2_on <= i[5];
			repeat (3) @(posedge pclk);
			chk(usb_pad_power, i[0] | i[3]);
			chk(first_pullup_switch, !i[1] & i[3] & i[4]);
			chk(second_pullup_switch, i[2] | (i[3] & i[5]));
		end
		// Calibration against each reference, interrupt unmasked then masked
		wr(12'h008, 16'h0003);
		for (int k = 0; k < 4; k++) begin
			wr(12'h3C8, {15'h0, k < 3});
			wr(12'h000, 16'h0004 | k[15:0]);
			r = 32'h4;
			for (int p = 0; p < 500 && r[2] !== 1'b0; p++) apb(1'b0, 12'h000, 32'h0, r);
			chk(r, k);
			apb(1'b0, 12'h010, 32'h0, r);
			apb(1'b0, 12'h018, 32'h0, h);
			h = {h[15:0], r[15:0]};
			chk(h >= rp[k] - 2 && h <= 3 * rp[k] / 2 + 4, 1);
			repeat (2) @(posedge pclk);
			chk(irq, k < 3);
			apb(1'b0, 12'h3C0, 32'h0, r);
			chk(r, 32'h1);
			wr(12'h3C0, 16'h0001);
			repeat (2) @(posedge pclk);
			chk(irq, 1'b0);
		end
		end_of_test();
	end
endmodule
